/* File: bench/kbd_link_port_properties.sv */
// concurrent checks on the link port's ports
`timescale 1ns/1ps
module kbd_link_port_properties (
    input logic       I_MCLK,
    input logic       I_RESET_N,
    input logic       I_ENABLE,
    input logic       I_TX_MASK,
    input logic       I_RX_MASK,
    input logic       I_RX_READY,
    input logic       O_TX_READY,
    input logic [7:0] O_RX_DATA,
    input logic       O_RX_VALID,
    input logic       O_DATA_PULLDOWN_EN_N,
    input logic       O_CLOCK_PULLDOWN_EN_N,
    input logic       O_TX_INTERRUPT,
    input logic       O_RX_INTERRUPT,
    input logic       O_COMBINED_INTERRUPT
);
    int low_cnt;

    // cycles the clock pulldown has stood, cleared on release
    always @(posedge I_MCLK) begin
        if (!I_RESET_N || O_CLOCK_PULLDOWN_EN_N) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= low_cnt + 1;
        end
    end

    default clocking dc @(posedge I_MCLK); endclocking
    default disable iff (!I_RESET_N);

    // request-to-send: long clock low, data low, then clock freed
    sequence s_data_low;
        $fell(O_DATA_PULLDOWN_EN_N) && !O_CLOCK_PULLDOWN_EN_N;
    endsequence
    sequence s_clk_free;
        ##[1:40] O_CLOCK_PULLDOWN_EN_N;
    endsequence

    property p_rts;
        s_data_low |-> (low_cnt >= 510) ##0 s_clk_free;
    endproperty
    property p_comb;
        O_COMBINED_INTERRUPT == (O_TX_INTERRUPT || O_RX_INTERRUPT);
    endproperty
    property p_txint;
        O_TX_INTERRUPT |-> O_TX_READY;
    endproperty
    property p_rxint;
        O_RX_INTERRUPT |-> O_RX_VALID;
    endproperty
    property p_txmask;
        !I_TX_MASK [*4] |-> !O_TX_INTERRUPT;
    endproperty
    property p_rxmask;
        I_RX_MASK [*4] ##0 O_RX_VALID |-> O_RX_INTERRUPT;
    endproperty
    property p_idle;
        !I_ENABLE [*5] |-> O_DATA_PULLDOWN_EN_N && O_CLOCK_PULLDOWN_EN_N;
    endproperty
    property p_rxhold;
        O_RX_VALID && !I_RX_READY |=> O_RX_VALID && $stable(O_RX_DATA);
    endproperty

    a_rts: assert property (p_rts)
        else $error("request-to-send timing wrong");
    a_comb: assert property (p_comb)
        else $error("combined interrupt wrong");
    a_txint: assert property (p_txint)
        else $error("tx interrupt without room");
    a_rxint: assert property (p_rxint)
        else $error("rx interrupt without byte");
    a_txmask: assert property (p_txmask)
        else $error("masked tx interrupt seen");
    a_rxmask: assert property (p_rxmask)
        else $error("unmasked rx interrupt missing");
    a_idle: assert property (p_idle)
        else $error("line pulled while disabled");
    a_rxhold: assert property (p_rxhold)
        else $error("received byte lost before read");
endmodule // kbd_link_port_properties

bind kbd_link_port kbd_link_port_properties u_props (
    .I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N), .I_ENABLE(I_ENABLE),
    .I_TX_MASK(I_TX_MASK), .I_RX_MASK(I_RX_MASK), .I_RX_READY(I_RX_READY),
    .O_TX_READY(O_TX_READY), .O_RX_DATA(O_RX_DATA), .O_RX_VALID(O_RX_VALID),
    .O_DATA_PULLDOWN_EN_N(O_DATA_PULLDOWN_EN_N),
    .O_CLOCK_PULLDOWN_EN_N(O_CLOCK_PULLDOWN_EN_N),
    .O_TX_INTERRUPT(O_TX_INTERRUPT), .O_RX_INTERRUPT(O_RX_INTERRUPT),
    .O_COMBINED_INTERRUPT(O_COMBINED_INTERRUPT));

/* File: bench/kbd_link_port_test.sv */
// self-checking bench for the link port with a keyboard model
`timescale 1ns/1ps
module kbd_link_port_test;
    logic       mclk = 1'b0, reset_n = 1'b0, enable = 1'b0;
    logic       tx_mask = 1'b0, rx_mask = 1'b0, test_mode = 1'b0;
    logic       tx_valid = 1'b0, rx_ready = 1'b0, dpd_q = 1'b1;
    logic [3:0] divisor = 4'h0;
    logic [7:0] tx_data = 8'h00, b, q[$];
    wire  [7:0] rx_data;
    wire        rx_perr, rx_valid, tx_ready, dpd_n, cpd_n;
    wire        tx_int, rx_int, any_int, link_clock, link_data;
    wire        busy, ldo, lco;
    int         err_count = 0, checked = 0, rts_len = 0, lo_run = 0;

    always #25 mclk = ~mclk;

    kbd_link_port uut (
        .I_MCLK(mclk), .I_RESET_N(reset_n), .I_ENABLE(enable),
        .I_DIVISOR(divisor), .I_TX_MASK(tx_mask), .I_RX_MASK(rx_mask),
        .I_TEST_MODE(test_mode), .I_TX_DATA(tx_data),
        .I_TX_VALID(tx_valid), .O_TX_READY(tx_ready), .O_RX_DATA(rx_data),
        .O_RX_PARITY_ERR(rx_perr), .O_RX_VALID(rx_valid),
        .I_RX_READY(rx_ready), .I_LINK_DATA_IN(link_data),
        .I_LINK_CLOCK_IN(link_clock), .O_LINK_DATA_OUT(ldo),
        .O_LINK_CLOCK_OUT(lco), .O_DATA_PULLDOWN_EN_N(dpd_n),
        .O_CLOCK_PULLDOWN_EN_N(cpd_n), .O_BUSY(busy),
        .O_TX_INTERRUPT(tx_int), .O_RX_INTERRUPT(rx_int),
        .O_COMBINED_INTERRUPT(any_int));

    kbd_peripheral_model peer (
        .clock_pulldown_en_n(cpd_n), .data_pulldown_en_n(dpd_n),
        .link_clock(link_clock), .link_data(link_data));

    // clock-low run length at the moment data is pulled
    always @(posedge mclk) begin
        lo_run <= cpd_n ? 0 : lo_run + 1;
        dpd_q <= dpd_n;
        if (dpd_q && !dpd_n && !cpd_n) rts_len <= lo_run;
    end

    task step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask

    task chk(input string what, input logic [15:0] exp, got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    task chk_in(input string what, input int lo, hi, got);
        checked++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("BAD %s exp %0d..%0d got %0d", what, lo, hi, got);
        end
    endtask

    task test_done;
        $display("checked %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task hang(input string what);
        err_count++;
        $display("BAD %s exp done got timeout", what);
        test_done;
    endtask

    // one byte into the queue; waits for room, bounded
    task push(input logic [7:0] v);
        int i;
        for (i = 0; i < 30000 && tx_ready !== 1'b1; i++) step(1);
        if (tx_ready !== 1'b1) hang("tx room");
        tx_data = v;
        tx_valid = 1'b1;
        step(1);
        tx_valid = 1'b0;
        step(1);
    endtask

    task expect_tx(input logic [7:0] v);
        int         i;
        logic [9:0] f;
        for (i = 0; i < 20000 && peer.got_q.size() == 0; i++) step(1);
        if (peer.got_q.size() == 0) hang("tx frame");
        f = peer.got_q.pop_front();
        chk("tx frame", {1'b1, ~^v, v}, f);
    endtask

    task read_rx(input logic [7:0] v, input logic perr);
        int i;
        for (i = 0; i < 20000 && rx_valid !== 1'b1; i++) step(1);
        if (rx_valid !== 1'b1) hang("rx byte");
        chk("rx byte", v, rx_data);
        chk("rx parity", perr, rx_perr);
        chk("rx int", {rx_mask, rx_mask | tx_mask},
            {rx_int, any_int});
        rx_ready = 1'b1;
        step(1);
        rx_ready = 1'b0;
        chk("rx taken", 1'b0, rx_valid);
    endtask

    // main sequence; slow peer later stands in for a stalling far side
    initial begin
        int dv[3] = '{0, 1, 15};
        int i;
        void'($urandom(32'h62f9));
        step(10);
        reset_n = 1'b1;
        chk("pads", 2'b11, {dpd_n, cpd_n});
        chk("idle", 3'b100, {tx_ready, rx_valid, any_int});
        chk("outs", 3'b000, {busy, ldo, lco});
        enable = 1'b1;
        tx_mask = 1'b1;
        rx_mask = 1'b1;
        step(4);
        chk("tx int", 2'b11, {tx_int, any_int});
        for (i = 0; i < 3; i++) begin
            divisor = dv[i];
            peer.half_ns = 500 * (dv[i] + 1);
            step(4);
            b = $urandom;
            push(b);
            expect_tx(b);
            chk_in("rts", 512*(dv[i]+1)-2, 514*(dv[i]+1)+4,
                   rts_len);
            b = $urandom;
            peer.send(b, 1'b0);
            read_rx(b, 1'b0);
            $display("test divisor %0d done", dv[i]);
        end
        divisor = 4'h0;
        peer.half_ns = 500;
        b = $urandom;
        peer.send(b, 1'b1);
        read_rx(b, 1'b1);
        tx_mask = 1'b0;
        rx_mask = 1'b0;
        step(4);
        chk("tx masked", 1'b0, tx_int);
        b = $urandom;
        peer.send(b, 1'b0);
        read_rx(b, 1'b0);
        tx_mask = 1'b1;
        rx_mask = 1'b1;
        $display("test parity and masks done");
        enable = 1'b0;
        step(4);
        for (i = 0; i < 16; i++) begin
            b = $urandom;
            q.push_back(b);
            push(b);
        end
        chk("full", 1'b0, tx_ready);
        tx_data = 8'hee;
        tx_valid = 1'b1;
        step(3);
        tx_valid = 1'b0;
        enable = 1'b1;
        peer.half_ns = 3000;
        step(4);
        chk("busy", 1'b1, busy);
        for (i = 0; i < 16; i++) expect_tx(q[i]);
        step(3000);
        chk("refused", 16'h0000, peer.got_q.size());
        $display("test fill done");
        divisor = 4'hf;
        test_mode = 1'b1;
        peer.half_ns = 500;
        step(4);
        b = $urandom;
        push(b);
        expect_tx(b);
        chk_in("rts test", 510, 516, rts_len);
        $display("test mode done");
        test_done;
    end
endmodule // kbd_link_port_test

/* File: bench/kbd_peripheral_model.sv */
// behavioural keyboard on the two open-drain link lines
`timescale 1ns/1ps
module kbd_peripheral_model (
    input  wire logic clock_pulldown_en_n,
    input  wire logic data_pulldown_en_n,
    output wire logic link_clock,
    output wire logic link_data
);
    logic       clk_drv = 1'b1;
    logic       dat_drv = 1'b1;
    logic       sending = 1'b0;
    int         half_ns = 500;
    logic [9:0] got_q[$];
    logic [9:0] frame;
    logic       s;

    // wired-and with pull-ups, so a released line reads high
    assign link_clock = clock_pulldown_en_n & clk_drv;
    assign link_data  = data_pulldown_en_n & dat_drv;

    // one clock pulse; data sampled just before the rise
    task pulse(output logic smp);
        #half_ns clk_drv = 1'b0;
        #half_ns smp = link_data;
        clk_drv = 1'b1;
    endtask

    // frame to the host, parity spoilt only when asked
    task send(input logic [7:0] b, input logic bad);
        logic [10:0] f;
        int          i;
        f = {1'b1, (~^b) ^ bad, b, 1'b0};
        for (i = 0; i < 400 && link_clock !== 1'b1; i++) #1000;
        sending = 1'b1;
        for (i = 0; i < 11; i++) begin
            dat_drv = f[i];
            pulse(s);
        end
        dat_drv = 1'b1;
        sending = 1'b0;
    endtask

    // clock released while data held low: host wants to send
    always @(posedge link_clock) begin
        int k;
        if (link_data === 1'b0 && !sending) begin
            for (k = 0; k < 10; k++) pulse(frame[k]);
            dat_drv = 1'b0;
            pulse(s);
            dat_drv = 1'b1;
            got_q.push_back(frame);
        end
    end
endmodule // kbd_peripheral_model

/* File: core/bit_sync.v */
// two flip-flop level synchroniser, any width
`timescale 1ns/1ps
module bit_sync #(
    parameter         W    = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input  wire         i_clk,
    input  wire         i_reset_n,
    input  wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // first stage feeds only the second stage
    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            meta_reg <= INIT;
            sync_reg <= INIT;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule // bit_sync

/* File: core/kbd_link_map.vh */
// constants for the keyboard/mouse serial link port
`ifndef KBD_LINK_MAP_VH
`define KBD_LINK_MAP_VH

`define KBD_DIV_W        4
`define KBD_DIV_RESET    4'h0
`define KBD_RTS_TICKS    10'h200
`define KBD_RTS_W        10
`define KBD_TX_LAST      4'h9
`define KBD_FRAME_LAST   4'ha
`define KBD_FIFO_WIDTH   8
`define KBD_FIFO_DEPTH   16
`define KBD_FIFO_AW      4
`define KBD_BYTE_RESET   8'h00

`endif

/* File: core/kbd_link_port.v */
// keyboard/mouse two-wire serial link port, top level
// Operation
// - bytes to serial frames and back
// - pads released; pull low via active-low enables
// - 4-bit divider, value n divides by n+1
// - divide ratio loaded from divisor input
// - queued byte starts transmit when enabled
// - peripheral clock low starts receive
// - separately maskable transmit and receive interrupts
// - control levels synchronised before use
// - odd parity, framing, shift on clock fall
// - receiver samples data on synchronised clock fall
// - link data and clock synchronised
// - transmit wins over simultaneous receive
// - crossings into this domain synchronised
// - request-to-send low lasts 512 ticks
// - test mode forces tick every clock
// - frame is start, 8 data lsb first, parity, stop
// - parity high when data ones even
// - clock low, then data low, then release clock
`timescale 1ns/1ps
`include "kbd_link_map.vh"
module kbd_link_port (
    input  wire       I_MCLK,
    input  wire       I_RESET_N,
    input  wire       I_ENABLE,
    input  wire [3:0] I_DIVISOR,
    input  wire       I_TX_MASK,
    input  wire       I_RX_MASK,
    input  wire       I_TEST_MODE,
    input  wire [7:0] I_TX_DATA,
    input  wire       I_TX_VALID,
    output wire       O_TX_READY,
    output wire [7:0] O_RX_DATA,
    output wire       O_RX_PARITY_ERR,
    output wire       O_RX_VALID,
    input  wire       I_RX_READY,
    input  wire       I_LINK_DATA_IN,
    input  wire       I_LINK_CLOCK_IN,
    output wire       O_LINK_DATA_OUT,
    output wire       O_LINK_CLOCK_OUT,
    output wire       O_DATA_PULLDOWN_EN_N,
    output wire       O_CLOCK_PULLDOWN_EN_N,
    output wire       O_BUSY,
    output wire       O_TX_INTERRUPT,
    output wire       O_RX_INTERRUPT,
    output wire       O_COMBINED_INTERRUPT
);
    // sequencer states; one engine serves both directions because
    // the link is half duplex and only one frame is ever in flight
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_RTS  = 3'h1;
    localparam [2:0] ST_REQ  = 3'h2;
    localparam [2:0] ST_TX   = 3'h3;
    localparam [2:0] ST_RX   = 3'h4;


    // odd parity bit: high when the byte has an even count of ones
    // shared by the outgoing frame and the received-byte check
    function par_odd;
        input [7:0] b;
        begin
            par_odd = ~(^b);
        end
    endfunction

    wire [1:0]             link_s;
    wire [3:0]             ctrl_s;
    wire [`KBD_DIV_W-1:0]  div_s;
    wire                   clk_s;
    wire                   dat_s;
    wire                   en_s;
    wire                   txm_s;
    wire                   rxm_s;
    wire                   test_s;
    wire [7:0]             fifo_data;
    wire                   fifo_valid;
    wire                   fifo_pop;
    wire                   fall;
    wire                   step;

    reg [`KBD_DIV_W-1:0]   div_cnt_reg;
    reg                    tick_reg;
    reg                    clk_prev_reg;
    reg                    fall_pend_reg;
    reg [2:0]              state_reg;
    reg [3:0]              bit_cnt_reg;
    reg [`KBD_RTS_W-1:0]   rts_cnt_reg;
    reg [9:0]              tx_shift_reg;
    reg [8:0]              rx_shift_reg;
    reg                    clk_en_n_reg;
    reg                    dat_en_n_reg;
    reg [7:0]              rx_data_reg;
    reg                    rx_err_reg;
    reg                    rx_full_reg;

    // link pins come from another domain; idle level is high
    bit_sync #(.W(2), .INIT(2'h3)) u_link_sync (
        .i_clk     (I_MCLK),
        .i_reset_n (I_RESET_N),
        .i_async   ({I_LINK_CLOCK_IN, I_LINK_DATA_IN}),
        .o_sync    (link_s)
    );
    assign clk_s = link_s[1];
    assign dat_s = link_s[0];

    // control levels written on the bus side are resynchronised
    bit_sync #(.W(8), .INIT(8'h00)) u_ctrl_sync (
        .i_clk     (I_MCLK),
        .i_reset_n (I_RESET_N),
        .i_async   ({I_TEST_MODE, I_RX_MASK, I_TX_MASK, I_ENABLE,
                     I_DIVISOR}),
        .o_sync    ({ctrl_s, div_s})
    );
    assign en_s   = ctrl_s[0];
    assign txm_s  = ctrl_s[1];
    assign rxm_s  = ctrl_s[2];
    assign test_s = ctrl_s[3];

    // outgoing bytes queue here; the writer stalls when full
    sync_fifo #(
        .WIDTH (`KBD_FIFO_WIDTH),
        .DEPTH (`KBD_FIFO_DEPTH),
        .AW    (`KBD_FIFO_AW)
    ) u_tx_fifo (
        .i_clk     (I_MCLK),
        .i_reset_n (I_RESET_N),
        .i_data    (I_TX_DATA),
        .i_valid   (I_TX_VALID),
        .o_ready   (O_TX_READY),
        .o_data    (fifo_data),
        .o_valid   (fifo_valid),
        .i_ready   (fifo_pop)
    );

    // tick divider: divisor n gives one tick every n+1 clocks
    // the count restarts once it reaches the divisor, so shrinking
    // the divisor never stalls the tick for a full 16 clocks
    always @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            div_cnt_reg <= `KBD_DIV_RESET;
            tick_reg    <= 1'b0;
        end else if (div_cnt_reg >= div_s) begin
            div_cnt_reg <= `KBD_DIV_RESET;
            tick_reg    <= 1'b1;
        end else begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
            tick_reg    <= 1'b0;
        end
    end

    // test mode lets vectors step the logic on every clock
    assign step = tick_reg | test_s;

    // edge register; a fall is held until a tick consumes it
    // a short peripheral phase may end before the next tick, and
    // holding the fall keeps that edge from being lost
    assign fall = clk_prev_reg & ~clk_s;
    always @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            clk_prev_reg  <= 1'b1;
            fall_pend_reg <= 1'b0;
        end else begin
            clk_prev_reg <= clk_s;
            if (fall) begin
                fall_pend_reg <= 1'b1;
            end else if (step) begin
                fall_pend_reg <= 1'b0;
            end
        end
    end

    // transmit is checked before receive in idle
    assign fifo_pop = (state_reg == ST_IDLE) & step & en_s
                      & fifo_valid;

    // link sequencer
    // dropping enable abandons any frame in flight and frees the
    // pads at once; the peripheral then times out on its own
    always @(posedge I_MCLK) begin
        if (!I_RESET_N || !en_s) begin
            state_reg    <= ST_IDLE;
            bit_cnt_reg  <= 4'h0;
            rts_cnt_reg  <= {`KBD_RTS_W{1'b0}};
            tx_shift_reg <= 10'h3ff;
            rx_shift_reg <= 9'h000;
            clk_en_n_reg <= 1'b1;
            dat_en_n_reg <= 1'b1;
        end else if (step) begin
            case (state_reg)
                ST_IDLE: begin
                    bit_cnt_reg  <= 4'h0;
                    dat_en_n_reg <= 1'b1;
                    // full receive buffer inhibits the peripheral
                    clk_en_n_reg <= ~rx_full_reg;
                    if (fifo_valid) begin
                        tx_shift_reg <= {1'b1, par_odd(fifo_data),
                                         fifo_data};
                        rts_cnt_reg  <= {`KBD_RTS_W{1'b0}};
                        clk_en_n_reg <= 1'b0;
                        state_reg    <= ST_RTS;
                    end else if (fall_pend_reg && !rx_full_reg) begin
                        bit_cnt_reg <= 4'h1; // start bit seen
                        state_reg   <= ST_RX;
                    end
                end
                ST_RTS: begin
                    // hold clock low for the full request width
                    // width is counted in ticks, so it scales with
                    // the divisor, from 512 clocks at divisor 0 to 8192 at divisor 15
                    if (rts_cnt_reg == `KBD_RTS_TICKS - 1'b1) begin
                        dat_en_n_reg <= 1'b0;
                        state_reg    <= ST_REQ;
                    end else begin
                        rts_cnt_reg <= rts_cnt_reg + 1'b1;
                    end
                end
                ST_REQ: begin
                    clk_en_n_reg <= 1'b1;
                    state_reg    <= ST_TX;
                end
                ST_TX: begin
                    // falls 1 to 10 carry data, parity, stop
                    // fall 11 is the peripheral's acknowledge
                    if (fall_pend_reg) begin
                        bit_cnt_reg <= bit_cnt_reg + 1'b1;
                        if (bit_cnt_reg <= `KBD_TX_LAST) begin
                            dat_en_n_reg <= tx_shift_reg[0];
                            tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                        end else begin
                            // acknowledge clock from the peripheral
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_RX: begin
                    // falls 2 to 10 carry data and parity
                    if (fall_pend_reg) begin
                        bit_cnt_reg <= bit_cnt_reg + 1'b1;
                        if (bit_cnt_reg == `KBD_FRAME_LAST) begin
                            state_reg <= ST_IDLE; // stop bit
                        end else begin
                            rx_shift_reg <= {dat_s,
                                             rx_shift_reg[8:1]};
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end


    // receive holding byte; a new byte wins over a same-cycle read
    // the sequencer inhibits the peripheral while a byte waits,
    // so an unread byte is never overwritten
    always @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            rx_data_reg <= `KBD_BYTE_RESET;
            rx_err_reg  <= 1'b0;
            rx_full_reg <= 1'b0;
        end else if (en_s && step && state_reg == ST_RX && fall_pend_reg
                     && bit_cnt_reg == `KBD_FRAME_LAST) begin
            rx_data_reg <= rx_shift_reg[7:0];
            rx_err_reg  <= rx_shift_reg[8]
                           != par_odd(rx_shift_reg[7:0]);
            rx_full_reg <= 1'b1;
        end else if (I_RX_READY) begin
            rx_full_reg <= 1'b0;
        end
    end

    assign O_RX_DATA       = rx_data_reg;
    assign O_RX_PARITY_ERR = rx_err_reg;
    assign O_RX_VALID      = rx_full_reg;
    assign O_BUSY          = (state_reg != ST_IDLE);


    // pads only ever pull low
    // the drivers stay fixed at zero and only the enables toggle,
    // which keeps both pins open-drain against the pull-ups
    assign O_LINK_DATA_OUT       = 1'b0;
    assign O_LINK_CLOCK_OUT      = 1'b0;
    assign O_DATA_PULLDOWN_EN_N  = dat_en_n_reg;
    assign O_CLOCK_PULLDOWN_EN_N = clk_en_n_reg;


    // interrupts are levels, gated by the masks
    // transmit follows queue room rather than an empty queue,
    // so software may write ahead of the wire
    assign O_TX_INTERRUPT       = O_TX_READY & txm_s;
    assign O_RX_INTERRUPT       = rx_full_reg & rxm_s;
    assign O_COMBINED_INTERRUPT = O_TX_INTERRUPT
                                  | O_RX_INTERRUPT;
endmodule // kbd_link_port

/* File: core/sync_fifo.v */
// single clock fifo with valid/ready on both sides
`timescale 1ns/1ps
module sync_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             i_clk,
    input  wire             i_reset_n,
    input  wire [WIDTH-1:0] i_data,
    input  wire             i_valid,
    output wire             o_ready,
    output wire [WIDTH-1:0] o_data,
    output wire             o_valid,
    input  wire             i_ready
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;

    // full and empty come straight from the fill count
    assign o_ready = (count_reg != DEPTH[AW:0]);
    assign o_valid = (count_reg != {(AW+1){1'b0}});
    assign o_data  = mem_reg[rd_ptr_reg];
    assign push    = i_valid & o_ready;
    assign pop     = i_ready & o_valid;

    // storage needs no reset, only the pointers and the fill count do
    always @(posedge i_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_data;
        end
    end

    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // sync_fifo
